// [design/pwdt_map.svh]
`ifndef PWDT_MAP_SVH
`define PWDT_MAP_SVH

`define PWDT_CFG_ADDR   8'h0a
`define PWDT_RESERVED_BITS_HI    7
`define PWDT_RESERVED_BITS_LO    6
`define PWDT_PER_HI     5
`define PWDT_PER_LO     4
`define PWDT_MODE_BIT   3
`define PWDT_FEED_BIT   2
`define PWDT_EN_BIT     1
`define PWDT_LOCK_BIT   0

`define PWDT_RESERVED_BITS_RST   2'b00
`define PWDT_PER_RST    2'b11
`define PWDT_MODE_RST   1'b0

// Shortest interval in seconds; code n gives this value shifted left by n
`define PWDT_BASE_S     8'h10
`define PWDT_TICK_S     1
`define PWDT_CLK_HZ     50000000

`endif

// [design/pwdt_pkg.sv]
package pwdt_pkg;

  typedef enum logic [1:0] {
    PWDT_RUN,
    PWDT_DOWN,
    PWDT_OFF
  } pwdt_state_t;

  typedef logic [1:0] pwdt_per_t;

endpackage : pwdt_pkg

// [design/pwdt_tb_if.sv]
`timescale 1ns/10ps
interface pwdt_tb_if;
  logic tick;
  logic clear;

  modport tb  (output tick, input clear);
  modport ctl (input tick, output clear);
endinterface : pwdt_tb_if

// [design/pwdt_timebase.sv]
`timescale 1ns/10ps
module pwdt_timebase #(
  parameter int TICK_DIV = 50000000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Tick towards the watchdog
  pwdt_tb_if.tb     tb
);
  import pwdt_pkg::*;

  localparam int W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

  logic [W-1:0] div_reg;
  logic [W-1:0] div_next;
  logic         tick_reg;
  logic         tick_next;

  // Clearing on reload keeps each interval a whole number of ticks long
  always_comb begin
    div_next  = div_reg + W'(1);
    tick_next = 1'b0;
    if (tb.clear) begin
      div_next = '0;
    end else if (div_reg == W'(TICK_DIV - 1)) begin
      div_next  = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tb.tick = tick_reg;

endmodule : pwdt_timebase

// [design/pwdt_top.sv]
`timescale 1ns/10ps
`include "pwdt_map.svh"
module pwdt_top #(
  parameter int TICK_DIV = `PWDT_TICK_S * `PWDT_CLK_HZ
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_rd,
  output logic [7:0]               reg_rdata,
  // Factory options and system events
  input  wire logic                otp_lock,
  input  wire logic                otp_enable,
  input  wire logic                system_config_reset,
  input  wire logic                wake_up,
  // Status and power control
  output logic                     expired_flag,
  output logic                     power_off_pulse,
  output logic                     power_reset_pulse,
  output logic                     ldo_enable,
  output pwdt_pkg::pwdt_state_t    power_state
);
  import pwdt_pkg::*;

  pwdt_tb_if tbus ();

  pwdt_timebase #(.TICK_DIV(TICK_DIV)) u_timebase (
    .clk (clk),
    .rst (rst),
    .tb  (tbus.tb)
  );

  function automatic logic [7:0] interval(input pwdt_per_t sel);
    interval = `PWDT_BASE_S << sel;
  endfunction : interval

  logic [1:0]  reserved_bits_reg,  reserved_bits_next;
  pwdt_per_t   per_reg,   per_next;
  logic        mode_reg,  mode_next;
  logic        feed_reg,  feed_next;
  logic        en_reg,    en_next;
  logic        lock_reg,  lock_next;
  logic [7:0]  cnt_reg,   cnt_next;
  logic        exp_reg,   exp_next;
  logic        off_reg,   off_next;
  logic        prst_reg,  prst_next;
  logic        ldo_reg,   ldo_next;
  logic [7:0]  rdata_reg, rdata_next;
  pwdt_state_t state_reg, state_next;

  logic        wr_hit;
  logic        per_chg;
  logic        cfg_rst;
  logic        reload;
  logic        expiry;

  assign wr_hit  = reg_wr && (reg_addr == `PWDT_CFG_ADDR);
  assign per_chg = wr_hit && (reg_wdata[`PWDT_PER_HI:`PWDT_PER_LO] != per_reg);
  // Configuration returns to defaults on the external event or while going down
  assign cfg_rst = system_config_reset || (state_reg == PWDT_DOWN);
  assign reload  = feed_reg || per_chg || !en_reg || (state_reg != PWDT_RUN);
  assign expiry  = en_reg && (state_reg == PWDT_RUN) && !reload && tbus.tick
                   && (cnt_reg == 8'h01);
  assign tbus.clear = reload;

  // Configuration register
  always_comb begin
    reserved_bits_next = reserved_bits_reg;
    per_next  = per_reg;
    mode_next = mode_reg;
    feed_next = 1'b0;
    en_next   = en_reg;
    lock_next = lock_reg;
    if (cfg_rst) begin
      reserved_bits_next = `PWDT_RESERVED_BITS_RST;
      per_next  = `PWDT_PER_RST;
      mode_next = `PWDT_MODE_RST;
      en_next   = otp_enable;
      lock_next = otp_lock;
    end else if (wr_hit) begin
      reserved_bits_next = reg_wdata[`PWDT_RESERVED_BITS_HI:`PWDT_RESERVED_BITS_LO];
      per_next  = reg_wdata[`PWDT_PER_HI:`PWDT_PER_LO];
      mode_next = reg_wdata[`PWDT_MODE_BIT];
      feed_next = reg_wdata[`PWDT_FEED_BIT];
      en_next   = reg_wdata[`PWDT_EN_BIT] || (lock_reg && en_reg);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reserved_bits_reg <= `PWDT_RESERVED_BITS_RST;
      per_reg  <= `PWDT_PER_RST;
      mode_reg <= `PWDT_MODE_RST;
      feed_reg <= 1'b0;
      en_reg   <= otp_enable;
      lock_reg <= otp_lock;
    end else begin
      reserved_bits_reg <= reserved_bits_next;
      per_reg  <= per_next;
      mode_reg <= mode_next;
      feed_reg <= feed_next;
      en_reg   <= en_next;
      lock_reg <= lock_next;
    end
  end

  // Counter, expiry flag and power sequencing
  always_comb begin
    cnt_next   = cnt_reg;
    exp_next   = exp_reg;
    off_next   = 1'b0;
    prst_next  = 1'b0;
    ldo_next   = ldo_reg;
    state_next = state_reg;
    if (reload) begin
      cnt_next = interval(per_next);
    end else if (tbus.tick) begin
      cnt_next = cnt_reg - 8'h01;
    end
    if (feed_reg) begin
      exp_next = 1'b0;
    end
    if (!en_reg) begin
      exp_next = 1'b0;
    end
    case (state_reg)
      PWDT_RUN: begin
        if (expiry) begin
          exp_next   = 1'b1;
          off_next   = !mode_reg;
          prst_next  = mode_reg;
          ldo_next   = 1'b0;
          state_next = PWDT_DOWN;
        end
      end
      PWDT_DOWN: begin
        if (mode_reg) begin
          ldo_next   = 1'b1;
          state_next = PWDT_RUN;
        end else begin
          state_next = PWDT_OFF;
        end
      end
      PWDT_OFF: begin
        if (wake_up) begin
          ldo_next   = 1'b1;
          state_next = PWDT_RUN;
        end
      end
      default: begin
        state_next = PWDT_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg   <= interval(`PWDT_PER_RST);
      exp_reg   <= 1'b0;
      off_reg   <= 1'b0;
      prst_reg  <= 1'b0;
      ldo_reg   <= 1'b1;
      state_reg <= PWDT_RUN;
    end else begin
      cnt_reg   <= cnt_next;
      exp_reg   <= exp_next;
      off_reg   <= off_next;
      prst_reg  <= prst_next;
      ldo_reg   <= ldo_next;
      state_reg <= state_next;
    end
  end

  // Read path; unmapped addresses read as zero
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      rdata_next = 8'h00;
      if (reg_addr == `PWDT_CFG_ADDR) begin
        rdata_next = {reserved_bits_reg, per_reg, mode_reg, feed_reg, en_reg, lock_reg};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata         = rdata_reg;
  assign expired_flag      = exp_reg;
  assign power_off_pulse   = off_reg;
  assign power_reset_pulse = prst_reg;
  assign ldo_enable        = ldo_reg;
  assign power_state       = state_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_going_down;
    state_reg == PWDT_DOWN;
  endsequence

  sequence s_back_up;
    (state_reg == PWDT_RUN) && ldo_reg && (per_reg == `PWDT_PER_RST) && !mode_reg;
  endsequence

  feed_reload_a: assert property (feed_reg && en_reg && state_reg == PWDT_RUN
    && !cfg_rst && !wr_hit |=> cnt_reg == interval(per_reg))
    else $error("feed did not reload the full interval");
  period_reload_a: assert property (per_chg && !cfg_rst && en_reg
    && state_reg == PWDT_RUN |=> cnt_reg == interval(per_reg))
    else $error("period change did not reload the count");
  period_map_a: assert property (reload |=> cnt_reg == {$past(per_next) == 2'b11,
    $past(per_next) == 2'b10, $past(per_next) == 2'b01, $past(per_next) == 2'b00, 4'h0})
    else $error("interval does not match period code");
  action_sel_a: assert property (expiry |=> (power_off_pulse == !$past(mode_reg))
    && (power_reset_pulse == $past(mode_reg)))
    else $error("wrong expiry action");
  // A fresh feed write in the same cycle legally sets the bit again
  feed_clear_a: assert property (feed_reg && !(wr_hit && reg_wdata[`PWDT_FEED_BIT])
    |=> !feed_reg)
    else $error("feed bit stayed set");
  disabled_quiet_a: assert property (!en_reg |=> !expired_flag)
    else $error("expired flag set while disabled");
  expiry_flag_a: assert property (expiry |=> expired_flag ##0 s_going_down)
    else $error("expiry did not set the flag");
  lock_ro_a: assert property (wr_hit && !cfg_rst |=> $stable(lock_reg))
    else $error("lock bit changed by a write");
  unlock_free_a: assert property (wr_hit && !cfg_rst && !lock_reg
    |=> en_reg == $past(reg_wdata[`PWDT_EN_BIT]))
    else $error("enable not written while unlocked");
  lock_hold_a: assert property (wr_hit && !cfg_rst && lock_reg && en_reg |=> en_reg)
    else $error("enable cleared while locked");
  reserved_bits_store_a: assert property (wr_hit && !cfg_rst
    |=> reserved_bits_reg == $past(reg_wdata[`PWDT_RESERVED_BITS_HI:`PWDT_RESERVED_BITS_LO]))
    else $error("reserved bits not stored");
  power_reset_a: assert property (s_going_down and mode_reg |=> s_back_up)
    else $error("power-reset did not come back up with defaults");
  power_off_a: assert property (s_going_down and !mode_reg
    |=> (state_reg == PWDT_OFF) && !ldo_reg)
    else $error("power-off did not stay off");
  action_once_a: assert property ((power_off_pulse || power_reset_pulse)
    |=> !power_off_pulse && !power_reset_pulse)
    else $error("expiry action raised twice");

endmodule : pwdt_top

// [test/pwdt_top_tb_top.sv]
`timescale 1ns/10ps
module pwdt_top_tb_top;
  import pwdt_pkg::*;
  localparam int TD = 4;
  logic        clk;
  logic        rst;
  logic        reg_wr;
  logic        reg_rd;
  logic        otp_lock;
  logic        otp_enable;
  logic        sys_cfg_rst;
  logic        wake_up;
  logic        exp_flag;
  logic        poff;
  logic        prst;
  logic        ldo;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  rd_val;
  logic [7:0]  seed;
  logic [2:0]  hits;
  pwdt_state_t pstate;
  int          num_errors;
  int          comparisons;

  pwdt_top #(.TICK_DIV(TD)) i_pwdt_top (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_lock(otp_lock), .otp_enable(otp_enable),
    .system_config_reset(sys_cfg_rst), .wake_up(wake_up), .expired_flag(exp_flag),
    .power_off_pulse(poff), .power_reset_pulse(prst), .ldo_enable(ldo), .power_state(pstate)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Feed bit never reads back once taken; lock only blocks clearing
  function automatic logic [7:0] cfg_exp(input logic [7:0] d, input logic lk, input logic en);
    return {d[7:3], 1'b0, d[1] | (lk & en), lk};
  endfunction : cfg_exp

  task automatic end_sim();
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Waits for the action pulse; n is the interval in ticks
  task automatic expire(input int n, input logic mode);
    int c;
    c = 0;
    while (!(poff === 1'b1 || prst === 1'b1) && c < 2000) begin
      @(posedge clk);
      #1;
      c++;
    end
    chk("interval", 8'h01, {7'h00, (c >= n * TD - 3 && c <= n * TD + 3)});
    chk("action", {6'h00, mode, ~mode}, {6'h00, prst, poff});
    chk("flag ldo", 8'h02, {6'h00, exp_flag, ldo});
    chk("down", {6'h00, PWDT_DOWN}, {6'h00, pstate});
    @(posedge clk);
    #1;
    chk("one pulse", 8'h00, {6'h00, prst, poff});
    if (!mode) begin
      repeat (5) @(posedge clk);
      #1;
      chk("off", {5'h00, PWDT_OFF, 1'b0}, {5'h00, pstate, ldo});
      @(posedge clk);
      wake_up <= 1'b1;
      @(posedge clk);
      wake_up <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
    end
    chk("run", {5'h00, PWDT_RUN, 1'b1}, {5'h00, pstate, ldo});
    rd(8'h0a, rd_val);
    chk("defaults", {4'h3, 2'b00, otp_enable, otp_lock}, rd_val);
  endtask : expire

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Longest path is the 128-tick interval plus the fixed scenarios
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial begin
    {reg_wr, reg_rd, otp_lock, sys_cfg_rst, wake_up} = 5'h00;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    otp_enable  = 1'b1;
    seed        = 8'h22;
    num_errors  = 0;
    comparisons = 0;
    rst         = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h0a, rd_val);
    chk("reset cfg", 8'h32, rd_val);
    // Every write also feeds, so random enables never expire here
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(8'h0a, seed | 8'h04);
      rd(8'h0a, rd_val);
      chk("cfg", cfg_exp(seed, 1'b0, 1'b0), rd_val);
    end
    wr(8'h0b, 8'hff);
    rd(8'h0b, rd_val);
    chk("unmapped", 8'h00, rd_val);
    rd(8'h0a, rd_val);
    chk("kept", cfg_exp(seed, 1'b0, 1'b0), rd_val);
    wr(8'h0a, 8'h04);
    hits = 3'h0;
    repeat (150) begin
      @(posedge clk);
      #1;
      hits = hits | {exp_flag, poff, prst};
    end
    chk("disabled", 8'h00, {5'h00, hits});
    wr(8'h0a, 8'h0e);
    repeat (5) begin
      repeat (40) @(posedge clk);
      wr(8'h0a, 8'h0e);
    end
    expire(16, 1'b1);
    for (int k = 0; k < 4; k++) begin
      wr(8'h0a, {2'b00, k[1:0], k[0], 3'b110});
      expire(16 << k, k[0]);
    end
    wr(8'h0a, 8'h16);
    repeat (90) @(posedge clk);
    wr(8'h0a, 8'h0a);
    expire(16, 1'b1);
    @(posedge clk);
    otp_lock    <= 1'b1;
    sys_cfg_rst <= 1'b1;
    @(posedge clk);
    sys_cfg_rst <= 1'b0;
    rd(8'h0a, rd_val);
    chk("locked cfg", 8'h33, rd_val);
    wr(8'h0a, 8'h00);
    rd(8'h0a, rd_val);
    chk("lock hold", cfg_exp(8'h00, 1'b1, 1'b1), rd_val);
    // Factory default off while locked: software may still set the enable
    @(posedge clk);
    otp_enable  <= 1'b0;
    sys_cfg_rst <= 1'b1;
    @(posedge clk);
    sys_cfg_rst <= 1'b0;
    rd(8'h0a, rd_val);
    chk("locked off", 8'h31, rd_val);
    chk("flag off", 8'h00, {7'h00, exp_flag});
    wr(8'h0a, 8'h02);
    rd(8'h0a, rd_val);
    chk("lock set", cfg_exp(8'h02, 1'b1, 1'b0), rd_val);
    end_sim();
  end
endmodule : pwdt_top_tb_top
